// ---- verilog/pas_consts.svh ----
`ifndef PAS_CONSTS_SVH
`define PAS_CONSTS_SVH
// Register indices; byte address is four times the index
`define PAS_IDX_SCALE 7'h71
`define PAS_IDX_AUTO 7'h72
`define PAS_IDX_CTRL 7'h7F
// Field positions
`define PAS_SCALE_AUTO_HI 24
`define PAS_SCALE_AUTO_LO 16
`define PAS_DUTY_HI 9
`define PAS_DUTY_LO 0
`define PAS_GRAD_HI 23
`define PAS_GRAD_LO 16
`define PAS_OFS_HI 7
`define PAS_OFS_LO 0
`define PAS_CTRL_AUTOEN 0
// Reset values
`define PAS_RST_SCALE_AUTO 9'h000
`define PAS_RST_DUTY 10'h000
`define PAS_RST_GRAD 8'h00
`define PAS_RST_OFS 8'h00
`define PAS_RST_AUTOEN 1'b1
// Field limits
`define PAS_SCALE_MAX 9'h0FF
`define PAS_DUTY_MAX 10'h3FF
// Bus answers
`define PAS_RESP_OKAY 2'h0
`define PAS_RESP_SLVERR 2'h2
`endif

// ---- verilog/pas_pkg.sv ----
package pas_pkg;
  typedef enum logic [1:0] {
    PAS_REG_NONE,
    PAS_REG_SCALE,
    PAS_REG_AUTO,
    PAS_REG_CTRL
  } pas_reg_e;
  typedef logic [31:0] pas_word_t;
endpackage

// ---- verilog/pas_coil_if.sv ----
`timescale 1ns/1ps
interface pas_coil_if #(parameter int SINE_W = 9);
  logic signed [SINE_W-1:0] sineA;
  logic signed [SINE_W-1:0] sineB;
  logic [9:0] duty;
  logic signed [SINE_W-1:0] scaledA;
  logic signed [SINE_W-1:0] scaledB;
  modport scaler (input sineA, input sineB, input duty,
                  output scaledA, output scaledB);
  modport feeder (output sineA, output sineB, output duty,
                  input scaledA, input scaledB);
endinterface

// ---- verilog/pas_duty_scaler.sv ----
`timescale 1ns/1ps
`include "pas_consts.svh"
module pas_duty_scaler #(
  parameter int SINE_W = 9
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Coil values
  pas_coil_if.scaler coil
);
  localparam int PW = SINE_W + 11;
  logic signed [SINE_W-1:0] aR_r, aR_nxt;
  logic signed [SINE_W-1:0] bR_r, bR_nxt;
  logic signed [PW-1:0] prodA;
  logic signed [PW-1:0] prodB;

  always_comb
  begin
    prodA = coil.sineA * $signed({1'b0, coil.duty});
    prodB = coil.sineB * $signed({1'b0, coil.duty});
    aR_nxt = aR_r;
    bR_nxt = bR_r;
    if (ce)
    begin
      aR_nxt = prodA[PW-2:10];
      bR_nxt = prodB[PW-2:10];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aR_r <= '0;
      bR_r <= '0;
    end
    else
    begin
      aR_r <= aR_nxt;
      bR_r <= bR_nxt;
    end
  end

  assign coil.scaledA = aR_r;
  assign coil.scaledB = bR_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_coil_scale: assert property (
    ce |=> (aR_r == $past(prodA[PW-2:10])) && (bR_r == $past(prodB[PW-2:10])))
    else $error("Coil value not scaled by duty cycle");
  chk_coil_hold: assert property (
    !ce |=> $stable(aR_r) && $stable(bR_r))
    else $error("Coil value moved while clock enable low");
  cov_full_duty: cover property (ce && coil.duty == `PAS_DUTY_MAX);
endmodule

// ---- verilog/pwm_amplitude_status_regs.sv ----
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "pas_consts.svh"
// How it works
// - Amplitude result readable, 255 means max voltage
// - Duty cycle scales both coil sine values
// - Duty cycle field spans 0 to 1023
// - Duty bits 9:2 match 8-bit duty values
// - Derived gradient and offset readable by software
// - Gradient at bits 23:16, resets zero
// - Offset at bits 7:0, same register
// - Automatic control active when enable set, default
module pwm_amplitude_status_regs #(
  parameter int ADDR_W = 12,
  parameter int SINE_W = 9
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Regulator results
  input wire logic [8:0] regScaleAuto,
  input wire logic [9:0] regDutyCycle,
  input wire logic [7:0] regGradient,
  input wire logic [7:0] regOffset,
  // Sine table and bridge values
  input wire logic signed [SINE_W-1:0] coilASineValue,
  input wire logic signed [SINE_W-1:0] coilBSineValue,
  output logic signed [SINE_W-1:0] coilAScaled,
  output logic signed [SINE_W-1:0] coilBScaled,
  // Control out to regulator
  output logic autoScaleEn,
  output logic [7:0] dutyCycleByte,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ****************************************
  // Decode and status fields
  // ****************************************
  function automatic pas_pkg::pas_reg_e regSel(input logic [ADDR_W-1:0] a);
    case (a[ADDR_W-1:2])
      (ADDR_W-2)'(`PAS_IDX_SCALE): return pas_pkg::PAS_REG_SCALE;
      (ADDR_W-2)'(`PAS_IDX_AUTO): return pas_pkg::PAS_REG_AUTO;
      (ADDR_W-2)'(`PAS_IDX_CTRL): return pas_pkg::PAS_REG_CTRL;
      default: return pas_pkg::PAS_REG_NONE;
    endcase
  endfunction
  logic [8:0] scale_r, scale_nxt;
  logic [9:0] duty_r, duty_nxt;
  logic [7:0] grad_r, grad_nxt;
  logic [7:0] ofs_r, ofs_nxt;
  logic autoEn_r, autoEn_nxt;

  always_comb
  begin
    scale_nxt = scale_r;
    duty_nxt = duty_r;
    grad_nxt = grad_r;
    ofs_nxt = ofs_r;
    if (ce)
    begin
      duty_nxt = regDutyCycle;
      if (autoEn_r)
      begin
        scale_nxt = regScaleAuto;
        grad_nxt = regGradient;
        ofs_nxt = regOffset;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scale_r <= `PAS_RST_SCALE_AUTO;
      duty_r <= `PAS_RST_DUTY;
      grad_r <= `PAS_RST_GRAD;
      ofs_r <= `PAS_RST_OFS;
    end
    else
    begin
      scale_r <= scale_nxt;
      duty_r <= duty_nxt;
      grad_r <= grad_nxt;
      ofs_r <= ofs_nxt;
    end
  end

  // upper duty bits feed 8-bit consumers
  assign dutyCycleByte = duty_r[9:2];
  assign autoScaleEn = autoEn_r;
  pas_coil_if #(.SINE_W(SINE_W)) coil ();
  assign coil.sineA = coilASineValue;
  assign coil.sineB = coilBSineValue;
  assign coil.duty = duty_r;
  assign coilAScaled = coil.scaledA;
  assign coilBScaled = coil.scaledB;
  pas_duty_scaler #(.SINE_W(SINE_W)) u_scaler (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .coil(coil)
  );

  // ****************************************
  // Bus slave
  // ****************************************
  logic awHave_r, awHave_nxt;
  logic wHave_r, wHave_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic wStrb0_r, wStrb0_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  pas_pkg::pas_word_t rdata_r, rdata_nxt;
  pas_pkg::pas_word_t rdMux;
  // Ready waits for ce so nothing is taken while frozen
  assign s_axi_awready = ce && !awHave_r;
  assign s_axi_wready = ce && !wHave_r;
  assign s_axi_arready = ce && !rvalid_r;
  always_comb
  begin
    rdMux = '0;
    case (regSel(s_axi_araddr))
      pas_pkg::PAS_REG_SCALE:
      begin
        rdMux[`PAS_SCALE_AUTO_HI:`PAS_SCALE_AUTO_LO] = scale_r;
        rdMux[`PAS_DUTY_HI:`PAS_DUTY_LO] = duty_r;
      end
      pas_pkg::PAS_REG_AUTO:
      begin
        rdMux[`PAS_GRAD_HI:`PAS_GRAD_LO] = grad_r;
        rdMux[`PAS_OFS_HI:`PAS_OFS_LO] = ofs_r;
      end
      pas_pkg::PAS_REG_CTRL: rdMux[`PAS_CTRL_AUTOEN] = autoEn_r;
      default: rdMux = '0;
    endcase
  end
  always_comb
  begin
    awHave_nxt = awHave_r;
    wHave_nxt = wHave_r;
    awAddr_nxt = awAddr_r;
    wData_nxt = wData_r;
    wStrb0_nxt = wStrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    autoEn_nxt = autoEn_r;
    if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_nxt = 1'b1;
        awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_nxt = 1'b1;
        wData_nxt = s_axi_wdata;
        wStrb0_nxt = s_axi_wstrb[0];
      end
      if (bvalid_r && s_axi_bready)
        bvalid_nxt = 1'b0;
      if (awHave_r && wHave_r && !bvalid_r)
      begin
        awHave_nxt = 1'b0;
        wHave_nxt = 1'b0;
        bvalid_nxt = 1'b1;
        bresp_nxt = `PAS_RESP_OKAY;
        if (regSel(awAddr_r) == pas_pkg::PAS_REG_CTRL && wStrb0_r)
          autoEn_nxt = wData_r[`PAS_CTRL_AUTOEN];
        if (regSel(awAddr_r) == pas_pkg::PAS_REG_NONE)
          bresp_nxt = `PAS_RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready)
        rvalid_nxt = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_nxt = 1'b1;
        rdata_nxt = rdMux;
        rresp_nxt = (regSel(s_axi_araddr) == pas_pkg::PAS_REG_NONE) ?
                    `PAS_RESP_SLVERR : `PAS_RESP_OKAY;
      end
    end
  end
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `PAS_RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= `PAS_RESP_OKAY;
      rdata_r <= '0;
      autoEn_r <= `PAS_RST_AUTOEN;
    end
    else
    begin
      awHave_r <= awHave_nxt;
      wHave_r <= wHave_nxt;
      awAddr_r <= awAddr_nxt;
      wData_r <= wData_nxt;
      wStrb0_r <= wStrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      autoEn_r <= autoEn_nxt;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire logic rdScale = s_axi_arvalid && s_axi_arready &&
                       regSel(s_axi_araddr) == pas_pkg::PAS_REG_SCALE;
  wire logic rdAuto = s_axi_arvalid && s_axi_arready &&
                      regSel(s_axi_araddr) == pas_pkg::PAS_REG_AUTO;
  chk_scale_readout: assert property (
    rdScale |=> s_axi_rvalid && s_axi_rdata[24:16] == $past(scale_r))
    else $error("Amplitude field read wrong");
  chk_duty_readout: assert property (
    rdScale |=> s_axi_rdata[9:0] == $past(duty_r) &&
                s_axi_rdata[15:10] == 6'h00 && s_axi_rdata[31:25] == 7'h00)
    else $error("Duty field read wrong");
  chk_duty_byte: assert property (
    ce |=> dutyCycleByte == $past(regDutyCycle[9:2]))
    else $error("Duty upper bits do not track");
  chk_grad_readout: assert property (
    rdAuto |=> s_axi_rdata[23:16] == $past(grad_r) &&
               s_axi_rdata[31:24] == 8'h00)
    else $error("Gradient field read wrong");
  chk_ofs_readout: assert property (
    rdAuto |=> s_axi_rdata[7:0] == $past(ofs_r) &&
               s_axi_rdata[15:8] == 8'h00)
    else $error("Offset field read wrong");
  chk_auto_track: assert property (
    ce && autoEn_r |=> grad_r == $past(regGradient) &&
                       ofs_r == $past(regOffset))
    else $error("Derived values not tracking");
  chk_auto_hold: assert property (
    !autoEn_r |=> $stable(grad_r) && $stable(ofs_r) && $stable(scale_r))
    else $error("Results moved while automatic control off");
  chk_write_ignored: assert property (
    awHave_r && wHave_r && !bvalid_r && ce &&
    regSel(awAddr_r) != pas_pkg::PAS_REG_CTRL |=> $stable(autoEn_r))
    else $error("Status write changed control");
  chk_write_answer: assert property (
    awHave_r && wHave_r && !bvalid_r && ce |=> s_axi_bvalid)
    else $error("Write response late");
  cov_read_scale: cover property (rdScale ##1 s_axi_rvalid);
  cov_auto_off: cover property (autoEn_r ##1 !autoEn_r);
  cov_bad_addr: cover property (s_axi_bvalid &&
                                s_axi_bresp == `PAS_RESP_SLVERR);
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "pas_consts.svh"
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin errorCnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [8:0] regScaleAuto = 9'h000;
  logic [9:0] regDutyCycle = 10'h000;
  logic [7:0] regGradient = 8'h00;
  logic [7:0] regOffset = 8'h00;
  logic signed [8:0] coilASineValue = 9'h000;
  logic signed [8:0] coilBSineValue = 9'h000;
  logic signed [8:0] coilAScaled, coilBScaled;
  logic autoScaleEn;
  logic [7:0] dutyCycleByte;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errorCnt = 0;
  int nChecks = 0;
  localparam logic [11:0] A_SCALE = {3'h0, `PAS_IDX_SCALE, 2'h0};
  localparam logic [11:0] A_AUTO = {3'h0, `PAS_IDX_AUTO, 2'h0};
  localparam logic [11:0] A_CTRL = {3'h0, `PAS_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_NONE = 12'h100;

  pwm_amplitude_status_regs dut (
    .core_clk, .nrst, .ce, .regScaleAuto, .regDutyCycle, .regGradient,
    .regOffset, .coilASineValue, .coilBSineValue, .coilAScaled,
    .coilBScaled, .autoScaleEn, .dutyCycleByte, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  // ****************************************
  // Bus, regulator and report tasks
  // ****************************************
  task automatic results;
    begin
      $display("Checks %0d, mismatches %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // Each channel is released only at the edge that takes it
  task automatic wrc(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    bit done;
    begin
      done = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
        @(posedge core_clk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
          s_axi_bready <= 1'b0;
          `CHK("bresp", er, s_axi_bresp)
          done = 1'b1;
        end
      end
      if (!done)
      begin
        errorCnt++;
        results();
      end
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    bit done;
    begin
      done = 1'b0;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 50 && !done; n++)
      begin
        @(posedge core_clk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
          s_axi_rready <= 1'b0;
          `CHK("rdata", ed, s_axi_rdata)
          `CHK("rresp", er, s_axi_rresp)
          done = 1'b1;
        end
      end
      if (!done)
      begin
        errorCnt++;
        results();
      end
    end
  endtask

  // Regulator outputs are level signals; three edges cover the latency
  task automatic setReg(input logic [8:0] s, input logic [9:0] d,
                        input logic [7:0] g, input logic [7:0] o);
    begin
      @(posedge core_clk);
      regScaleAuto <= s;
      regDutyCycle <= d;
      regGradient <= g;
      regOffset <= o;
      repeat (3) @(posedge core_clk);
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  int sa[4] = '{100, 255, 100, -7};
  int sb[4] = '{-100, -256, -1, 7};
  int sd[4] = '{512, 1023, 0, 1023};
  initial
  begin
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    rdc(A_SCALE, 32'h0000_0000, `PAS_RESP_OKAY);
    rdc(A_AUTO, 32'h0000_0000, `PAS_RESP_OKAY);
    rdc(A_CTRL, 32'h0000_0001, `PAS_RESP_OKAY);
    `CHK("autoScaleEn", 1'b1, autoScaleEn)
    setReg(9'h0FF, 10'h3FF, 8'hA5, 8'h5A);
    rdc(A_SCALE, 32'h00FF_03FF, `PAS_RESP_OKAY);
    rdc(A_AUTO, 32'h00A5_005A, `PAS_RESP_OKAY);
    `CHK("dutyCycleByte", 8'hFF, dutyCycleByte)
    setReg(9'h05A, 10'h2B7, 8'h3C, 8'hC3);
    rdc(A_SCALE, 32'h005A_02B7, `PAS_RESP_OKAY);
    rdc(A_AUTO, 32'h003C_00C3, `PAS_RESP_OKAY);
    `CHK("dutyCycleByte", 8'hAD, dutyCycleByte)
    wrc(A_SCALE, 32'hFFFF_FFFF, `PAS_RESP_OKAY);
    wrc(A_AUTO, 32'hFFFF_FFFF, `PAS_RESP_OKAY);
    rdc(A_SCALE, 32'h005A_02B7, `PAS_RESP_OKAY);
    rdc(A_AUTO, 32'h003C_00C3, `PAS_RESP_OKAY);
    wrc(A_NONE, 32'h0000_0001, `PAS_RESP_SLVERR);
    rdc(A_NONE, 32'h0000_0000, `PAS_RESP_SLVERR);
    // Disabled control freezes results while duty keeps tracking
    wrc(A_CTRL, 32'h0000_0000, `PAS_RESP_OKAY);
    setReg(9'h033, 10'h155, 8'h11, 8'h22);
    `CHK("autoScaleEn", 1'b0, autoScaleEn)
    rdc(A_CTRL, 32'h0000_0000, `PAS_RESP_OKAY);
    rdc(A_SCALE, 32'h005A_0155, `PAS_RESP_OKAY);
    rdc(A_AUTO, 32'h003C_00C3, `PAS_RESP_OKAY);
    wrc(A_CTRL, 32'h0000_0001, `PAS_RESP_OKAY);
    setReg(9'h033, 10'h155, 8'h11, 8'h22);
    rdc(A_SCALE, 32'h0033_0155, `PAS_RESP_OKAY);
    rdc(A_AUTO, 32'h0011_0022, `PAS_RESP_OKAY);
    // Both coil values scaled by the same duty, truncated toward minus
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      coilASineValue <= 9'(sa[i]);
      coilBSineValue <= 9'(sb[i]);
      setReg(9'h033, 10'(sd[i]), 8'h11, 8'h22);
      `CHK("coilAScaled", 9'((sa[i] * sd[i]) >>> 10), coilAScaled)
      `CHK("coilBScaled", 9'((sb[i] * sd[i]) >>> 10), coilBScaled)
    end
    // Clock enable low must freeze duty and coil outputs
    @(posedge core_clk);
    ce <= 1'b0;
    coilASineValue <= 9'h064;
    setReg(9'h044, 10'h000, 8'h55, 8'h66);
    `CHK("dutyCycleByte", 8'hFF, dutyCycleByte)
    `CHK("coilAScaled", 9'h1F9, coilAScaled)
    @(posedge core_clk);
    ce <= 1'b1;
    setReg(9'h044, 10'h000, 8'h55, 8'h66);
    `CHK("dutyCycleByte", 8'h00, dutyCycleByte)
    `CHK("coilAScaled", 9'h000, coilAScaled)
    rdc(A_AUTO, 32'h0055_0066, `PAS_RESP_OKAY);
    rdc(A_SCALE, 32'h0044_0000, `PAS_RESP_OKAY);
    results();
  end
endmodule
